// >>> inc/itic_pkg.sv
// Constants and types for the translation cache invalidate command block.
package itic_pkg;
	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_IVA_LO = 8'h00;
	localparam logic [7:0] ADDR_IVA_HI = 8'h04;
	localparam logic [7:0] ADDR_CMD_LO = 8'h08;
	localparam logic [7:0] ADDR_CMD_HI = 8'h0C;
	localparam logic [7:0] ADDR_CAP = 8'h10;
	localparam logic [7:0] ADDR_STS = 8'h14;
	localparam logic [7:0] ADDR_MASK = 8'h18;
	// ----------------------------------------
	// Field positions inside the command high word, the address low word and the status register
	// ----------------------------------------
	localparam int REQ_BIT = 31;
	localparam int RSV_BIT = 30;
	localparam int RG_LO = 28;
	localparam int AG_LO = 25;
	localparam int DOM_LO = 0;
	localparam int DOM_W = 16;
	localparam int AM_LO = 0;
	localparam int AM_W = 6;
	localparam int ST_DONE = 0;
	localparam int ST_IGN = 1;
	// ----------------------------------------
	// Encodings and reset values
	// ----------------------------------------
	localparam logic [1:0] GR_NONE = 2'h0;
	localparam logic [1:0] GR_GLOB = 2'h1;
	localparam logic [1:0] GR_DOM = 2'h2;
	localparam logic [1:0] GR_PAGE = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] RST_STS = 2'h0;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FLUSH = 2'b01,
		ST_INVAL = 2'b10
	} itic_state_t;
endpackage : itic_pkg

// >>> rtl/itic_top.sv
// Translation cache invalidate command register with AXI4-Lite access.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// - A write of the top byte with bit 63 set starts an invalidation.
// - On completion the request bit clears and actual granularity loads together.
// - With flush capability set, the write buffer drains before invalidating.
// - The command register sits eight bytes above the address register.
// - Requested granularity 00 reserved, 01 global, 10 domain, 11 page.
// - Coarser scope allowed; 00 reported when a bad request is ignored.
module itic_top
	import itic_pkg::*;
#(
	parameter logic FLUSH_REQUIRED = 1'b1,
	parameter logic [AM_W-1:0] MAX_AM = 6'h09
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [7:0] AWADDR,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [7:0] ARADDR,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	input wire logic CTX_PEND,
	output logic FLUSH_REQ,
	input wire logic FLUSH_ACK,
	output logic INV_REQ,
	input wire logic INV_ACK,
	output logic [1:0] INV_SCOPE,
	output logic [DOM_W-1:0] INV_DOMAIN,
	output logic [63:0] INV_ADDR,
	output logic IRQ
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic aw_full_r, w_full_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r, rdata_r;
	logic [3:0] w_strb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] iva_lo_r, iva_hi_r;
	logic req_r;
	logic [1:0] rg_r, ag_r;
	logic [DOM_W-1:0] dom_r;
	logic [1:0] sts_r, mask_r;
	logic flush_req_r, inv_req_r, irq_r;
	itic_state_t state_r, state_nxt;
	// ----------------------------------------
	// Write channel decode
	// ----------------------------------------
	// A write needs both halves held and the previous response gone.
	wire do_wr = CE && aw_full_r && w_full_r && !bvalid_r;
	wire aw_take = CE && AWVALID && awready_r;
	wire w_take = CE && WVALID && wready_r;
	wire aw_full_nxt = (aw_full_r && !do_wr) || aw_take;
	wire w_full_nxt = (w_full_r && !do_wr) || w_take;
	wire [7:0] wa = aw_addr_r;
	wire wr_ok = (wa == ADDR_IVA_LO) || (wa == ADDR_IVA_HI) || (wa == ADDR_CMD_LO)
		|| (wa == ADDR_CMD_HI) || (wa == ADDR_CAP) || (wa == ADDR_STS) || (wa == ADDR_MASK);
	// The address register is locked while a request runs, so the engine sees stable inputs.
	wire iva_wr = do_wr && !req_r && ((wa == ADDR_IVA_LO) || (wa == ADDR_IVA_HI));
	wire cmd_hi_wr = do_wr && (wa == ADDR_CMD_HI) && !req_r;
	wire start = cmd_hi_wr && w_strb_r[3] && w_data_r[REQ_BIT];
	wire mask_wr = do_wr && (wa == ADDR_MASK);
	// ----------------------------------------
	// Read channel decode
	// ----------------------------------------
	wire ar_take = CE && ARVALID && arready_r;
	wire sts_rd = ar_take && (ARADDR == ADDR_STS);
	logic [31:0] rd_mux;
	logic rd_ok;
	// Reserved bits, including bit 62, are never stored and read as zero.
	always_comb begin
		rd_mux = RST_WORD;
		rd_ok = 1'b1;
		if (ARADDR == ADDR_IVA_LO) begin
			rd_mux = iva_lo_r;
		end else if (ARADDR == ADDR_IVA_HI) begin
			rd_mux = iva_hi_r;
		end else if (ARADDR == ADDR_CMD_LO) begin
			rd_mux = RST_WORD;
		end else if (ARADDR == ADDR_CMD_HI) begin
			rd_mux[REQ_BIT] = req_r;
			rd_mux[RG_LO +: 2] = rg_r;
			rd_mux[AG_LO +: 2] = ag_r;
			rd_mux[DOM_LO +: DOM_W] = dom_r;
		end else if (ARADDR == ADDR_CAP) begin
			rd_mux[0] = FLUSH_REQUIRED;
		end else if (ARADDR == ADDR_STS) begin
			rd_mux[1:0] = sts_r;
		end else if (ARADDR == ADDR_MASK) begin
			rd_mux[1:0] = mask_r;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// ----------------------------------------
	// Request checking
	// ----------------------------------------
	// Reserved scope, an unsupported page mask or a pending context flush is ignored.
	wire am_bad = (rg_r == GR_PAGE) && (iva_lo_r[AM_LO +: AM_W] > MAX_AM);
	wire bad_req = (rg_r == GR_NONE) || am_bad || CTX_PEND;
	wire eval = (state_r == ST_IDLE) && req_r;
	wire ignore = CE && eval && bad_req;
	wire finish = CE && (state_r == ST_INVAL) && INV_ACK;
	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (eval && !bad_req) begin
					state_nxt = FLUSH_REQUIRED ? ST_FLUSH : ST_INVAL;
				end
			end
			ST_FLUSH: begin
				if (FLUSH_ACK) begin
					state_nxt = ST_INVAL;
				end
			end
			ST_INVAL: begin
				if (INV_ACK) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// AXI4-Lite handshake registers
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			aw_addr_r <= 8'h00;
			w_data_r <= RST_WORD;
			w_strb_r <= 4'h0;
		end else if (CE) begin
			aw_full_r <= aw_full_nxt;
			w_full_r <= w_full_nxt;
			awready_r <= !aw_full_nxt;
			wready_r <= !w_full_nxt;
			if (aw_take) begin
				aw_addr_r <= AWADDR;
			end
			if (w_take) begin
				w_data_r <= WDATA;
				w_strb_r <= WSTRB;
			end
			if (do_wr) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (BREADY) begin
				bvalid_r <= 1'b0;
			end
		end
	end
	// One read at a time; the answer appears the cycle after the address is taken.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= RST_WORD;
			rresp_r <= RESP_OKAY;
		end else if (CE) begin
			if (ar_take) begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= rd_mux;
				rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_r && RREADY) begin
				rvalid_r <= 1'b0;
				arready_r <= 1'b1;
			end else if (!rvalid_r) begin
				arready_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Address and command registers
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			iva_lo_r <= RST_WORD;
			iva_hi_r <= RST_WORD;
			dom_r <= '0;
			rg_r <= GR_NONE;
		end else if (CE) begin
			if (iva_wr) begin
				for (int i = 0; i < 4; i++) begin
					if (w_strb_r[i] && wa == ADDR_IVA_LO) iva_lo_r[i*8 +: 8] <= w_data_r[i*8 +: 8];
					if (w_strb_r[i] && wa == ADDR_IVA_HI) iva_hi_r[i*8 +: 8] <= w_data_r[i*8 +: 8];
				end
			end
			if (cmd_hi_wr && w_strb_r[0]) dom_r[7:0] <= w_data_r[7:0];
			if (cmd_hi_wr && w_strb_r[1]) dom_r[15:8] <= w_data_r[15:8];
			if (cmd_hi_wr && w_strb_r[3]) rg_r <= w_data_r[RG_LO +: 2];
		end
	end
	// The request bit clears and the actual scope loads in the same edge.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			req_r <= 1'b0;
			ag_r <= GR_NONE;
			state_r <= ST_IDLE;
		end else if (CE) begin
			state_r <= state_nxt;
			if (start) begin
				req_r <= 1'b1;
			end else if (ignore) begin
				req_r <= 1'b0;
				ag_r <= GR_NONE;
			end else if (finish) begin
				req_r <= 1'b0;
				ag_r <= rg_r;
			end
		end
	end

	// ----------------------------------------
	// Engine handshakes and interrupt
	// ----------------------------------------
	// A completion landing on a status read stays set: the set wins over the clear.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			flush_req_r <= 1'b0;
			inv_req_r <= 1'b0;
			sts_r <= RST_STS;
			mask_r <= RST_STS;
			irq_r <= 1'b0;
		end else if (CE) begin
			flush_req_r <= (state_nxt == ST_FLUSH) && !(state_r == ST_FLUSH && FLUSH_ACK);
			inv_req_r <= (state_nxt == ST_INVAL) && !(state_r == ST_INVAL && INV_ACK);
			sts_r[ST_DONE] <= finish || (sts_r[ST_DONE] && !sts_rd);
			sts_r[ST_IGN] <= ignore || (sts_r[ST_IGN] && !sts_rd);
			if (mask_wr && w_strb_r[0]) mask_r <= w_data_r[1:0];
			irq_r <= |(sts_r & mask_r);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign AWREADY = awready_r;
	assign WREADY = wready_r;
	assign BVALID = bvalid_r;
	assign BRESP = bresp_r;
	assign ARREADY = arready_r;
	assign RVALID = rvalid_r;
	assign RDATA = rdata_r;
	assign RRESP = rresp_r;
	assign FLUSH_REQ = flush_req_r;
	assign INV_REQ = inv_req_r;
	assign INV_SCOPE = rg_r;
	assign INV_DOMAIN = dom_r;
	assign INV_ADDR = {iva_hi_r, iva_lo_r};
	assign IRQ = irq_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_start;
		@(posedge CORE_CLK) disable iff (!RST_N) start |=> req_r;
	endproperty
	a_start: assert property (p_start) else $error("request bit not set by start");
	property p_gran;
		@(posedge CORE_CLK) disable iff (!RST_N)
			start |=> (rg_r == $past(w_data_r[RG_LO +: 2]));
	endproperty
	a_gran: assert property (p_gran) else $error("requested scope not captured");
	property p_done;
		@(posedge CORE_CLK) disable iff (!RST_N)
			finish |=> !req_r && (ag_r == rg_r) && (state_r == ST_IDLE);
	endproperty
	a_done: assert property (p_done) else $error("completion not reported");
	property p_busy;
		@(posedge CORE_CLK) disable iff (!RST_N)
			(req_r && do_wr) |=> $stable(rg_r) && $stable(iva_lo_r) && $stable(iva_hi_r);
	endproperty
	a_busy: assert property (p_busy) else $error("state changed while busy");
	property p_ctx;
		@(posedge CORE_CLK) disable iff (!RST_N)
			(CE && eval && CTX_PEND) |=> !req_r && (ag_r == GR_NONE) && sts_r[ST_IGN];
	endproperty
	a_ctx: assert property (p_ctx) else $error("request taken with context pending");
	property p_flush;
		@(posedge CORE_CLK) disable iff (!RST_N)
			(FLUSH_REQUIRED && $rose(inv_req_r)) |-> $past(state_r) == ST_FLUSH;
	endproperty
	a_flush: assert property (p_flush) else $error("invalidate before flush");
	property p_cmd_rd;
		@(posedge CORE_CLK) disable iff (!RST_N)
			(ar_take && ARADDR == ADDR_CMD_HI) |=> RVALID && (RDATA[REQ_BIT] == $past(req_r));
	endproperty
	a_cmd_rd: assert property (p_cmd_rd) else $error("command word read wrong");
	property p_bad;
		@(posedge CORE_CLK) disable iff (!RST_N)
			(CE && eval && rg_r == GR_NONE) |=> !req_r && ag_r == GR_NONE && !inv_req_r;
	endproperty
	a_bad: assert property (p_bad) else $error("reserved scope not ignored");
	property p_rsv;
		@(posedge CORE_CLK) disable iff (!RST_N)
			(ar_take && ARADDR == ADDR_CMD_HI) |=> !RDATA[RSV_BIT];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
	property p_irq;
		@(posedge CORE_CLK) disable iff (!RST_N)
			(CE && |(sts_r & mask_r)) |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule : itic_top

// >>> tb/tb.sv
// Self-checking bench for the translation cache invalidate command block.
`timescale 1ns/1ps
module tb;
	import itic_pkg::*;
	logic CORE_CLK, RST_N, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic CTX_PEND, FLUSH_ACK, INV_ACK, AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic FLUSH_REQ, INV_REQ, IRQ;
	logic [7:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP, INV_SCOPE;
	logic [15:0] INV_DOMAIN;
	logic [63:0] INV_ADDR;
	int mismatches = 0;
	int samples_checked = 0;
	itic_top i_itic_top (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA),
		.WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
		.RRESP(RRESP), .CTX_PEND(CTX_PEND), .FLUSH_REQ(FLUSH_REQ), .FLUSH_ACK(FLUSH_ACK),
		.INV_REQ(INV_REQ), .INV_ACK(INV_ACK), .INV_SCOPE(INV_SCOPE), .INV_DOMAIN(INV_DOMAIN),
		.INV_ADDR(INV_ADDR), .IRQ(IRQ));
	// ----------------------------------------
	// Clock, verdict and shared helpers
	// ----------------------------------------
	// The 40 MHz core clock.
	initial begin
		CORE_CLK = 1'b0;
		forever #12.5 CORE_CLK = ~CORE_CLK;
	end
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s: got %0h, expected %0h", $time, what, got, exp);
		end
	endtask : chk
	// Command high word as software reads it back.
	function automatic logic [31:0] cw(logic q, logic [1:0] rg, logic [1:0] ag, logic [15:0] d);
		return {q, 1'b0, rg, 1'b0, ag, 9'h0, d};
	endfunction : cw
	// Ready is sampled at the falling edge, where it is settled for the next rising edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic ta, tw, ha, hw, hb;
		logic [1:0] r;
		int n;
		@(posedge CORE_CLK);
		AWADDR <= a;
		WDATA <= d;
		WSTRB <= s;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		ta = 1'b0;
		tw = 1'b0;
		hb = 1'b0;
		for (n = 0; n < 40 && !hb; n++) begin
			@(negedge CORE_CLK);
			ha = !ta && AWREADY === 1'b1;
			hw = !tw && WREADY === 1'b1;
			hb = ta && tw && BVALID === 1'b1;
			r = BRESP;
			@(posedge CORE_CLK);
			if (ha) begin
				ta = 1'b1;
				AWVALID <= 1'b0;
			end
			if (hw) begin
				tw = 1'b1;
				WVALID <= 1'b0;
			end
		end
		BREADY <= 1'b0;
		chk(hb ? r : 2'h1, er, "write response");
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		logic ha, hr;
		logic [1:0] r;
		int n;
		@(posedge CORE_CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		hr = 1'b0;
		for (n = 0; n < 40 && !hr; n++) begin
			@(negedge CORE_CLK);
			ha = ARVALID && ARREADY === 1'b1;
			hr = !ARVALID && RVALID === 1'b1;
			r = RRESP;
			d = RDATA;
			@(posedge CORE_CLK);
			if (ha) begin
				ARVALID <= 1'b0;
			end
		end
		RREADY <= 1'b0;
		chk(hr ? r : 2'h1, er, "read response");
	endtask : rd
	// Waits under a bound for the flush (k=0) or invalidate (k=1) request.
	task automatic wait_hi(input int k);
		int n;
		for (n = 0; n < 40 && (k ? INV_REQ : FLUSH_REQ) !== 1'b1; n++) begin
			@(posedge CORE_CLK);
			#1;
		end
		chk(k ? INV_REQ : FLUSH_REQ, 1'b1, "engine request");
	endtask : wait_hi
	task automatic ack(input int k);
		@(posedge CORE_CLK);
		if (k) INV_ACK <= 1'b1;
		else FLUSH_ACK <= 1'b1;
		@(posedge CORE_CLK);
		INV_ACK <= 1'b0;
		FLUSH_ACK <= 1'b0;
	endtask : ack
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		rd(ADDR_CMD_HI, d, RESP_OKAY);
		chk(d, RST_WORD, "command reset");
		rd(ADDR_CMD_LO, d, RESP_OKAY);
		chk(d, 32'h0000_0000, "command low");
		rd(ADDR_CAP, d, RESP_OKAY);
		chk(d, 32'h0000_0001, "flush capability");
		wr(ADDR_CMD_HI, 32'h9000_0000, 4'h7, RESP_OKAY);
		rd(ADDR_CMD_HI, d, RESP_OKAY);
		chk({d, FLUSH_REQ}, 33'h0, "no top byte no start");
	endtask : t_reset
	// A good request also sets reserved bit 30 and tries to move the address while busy.
	task automatic t_good(input logic [1:0] rg, input logic [15:0] dom, input logic [31:0] lo);
		logic [31:0] d;
		wr(ADDR_IVA_LO, lo, 4'hF, RESP_OKAY);
		wr(ADDR_CMD_HI, {2'b11, rg, 12'h0, dom}, 4'hF, RESP_OKAY);
		wait_hi(0);
		chk(INV_REQ, 1'b0, "invalidate before drain");
		ack(0);
		wait_hi(1);
		chk({INV_SCOPE, INV_DOMAIN, INV_ADDR[31:0]}, {rg, dom, lo}, "target");
		rd(ADDR_CMD_HI, d, RESP_OKAY);
		chk(d[REQ_BIT], 1'b1, "busy");
		wr(ADDR_IVA_LO, ~lo, 4'hF, RESP_OKAY);
		ack(1);
		rd(ADDR_CMD_HI, d, RESP_OKAY);
		chk(d, cw(1'b0, rg, rg, dom), "completion");
		rd(ADDR_IVA_LO, d, RESP_OKAY);
		chk(d, lo, "address held while busy");
	endtask : t_good
	task automatic t_bad(input logic [1:0] rg, input logic [31:0] lo, input logic ctx);
		logic [31:0] d;
		wr(ADDR_IVA_LO, lo, 4'hF, RESP_OKAY);
		CTX_PEND <= ctx;
		wr(ADDR_CMD_HI, {2'b10, rg, 28'h0}, 4'hF, RESP_OKAY);
		CTX_PEND <= 1'b0;
		rd(ADDR_CMD_HI, d, RESP_OKAY);
		chk({d, FLUSH_REQ, INV_REQ}, {cw(1'b0, rg, GR_NONE, 16'h0), 2'b00}, "ignored");
		rd(ADDR_STS, d, RESP_OKAY);
		chk(d, 32'h0000_0002, "ignored status");
	endtask : t_bad
	// Holding the enable low across a drain acknowledge must leave the sequencer where it was.
	task automatic t_freeze();
		logic [31:0] d;
		wr(ADDR_CMD_HI, {2'b10, GR_GLOB, 28'h0}, 4'hF, RESP_OKAY);
		wait_hi(0);
		@(posedge CORE_CLK);
		CE <= 1'b0;
		FLUSH_ACK <= 1'b1;
		@(posedge CORE_CLK);
		FLUSH_ACK <= 1'b0;
		@(posedge CORE_CLK);
		CE <= 1'b1;
		@(posedge CORE_CLK);
		#1;
		chk({FLUSH_REQ, INV_REQ}, 2'b10, "frozen while disabled");
		ack(0);
		wait_hi(1);
		ack(1);
		rd(ADDR_CMD_HI, d, RESP_OKAY);
		chk(d, cw(1'b0, GR_GLOB, GR_GLOB, 16'h0), "completion after freeze");
	endtask : t_freeze
	// A reset in mid-run must drop a running request and its engine handshake.
	task automatic t_rst();
		logic [31:0] d;
		wr(ADDR_CMD_HI, {2'b10, GR_DOM, 28'h0}, 4'hF, RESP_OKAY);
		wait_hi(0);
		@(posedge CORE_CLK);
		RST_N <= 1'b0;
		repeat (3) @(posedge CORE_CLK);
		RST_N <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		chk({FLUSH_REQ, INV_REQ, IRQ}, 3'b000, "engine idle after reset");
		rd(ADDR_CMD_HI, d, RESP_OKAY);
		chk(d, RST_WORD, "request bit reset");
	endtask : t_rst
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		{RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, CTX_PEND, FLUSH_ACK, INV_ACK} = '0;
		{AWADDR, ARADDR, WDATA, WSTRB} = '0;
		CE = 1'b1;
		repeat (3) @(posedge CORE_CLK);
		RST_N <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		t_reset();
		wr(ADDR_MASK, 32'h0, 4'hF, RESP_OKAY);
		t_good(GR_GLOB, 16'h0000, 32'h0000_0000);
		chk(IRQ, 1'b0, "masked interrupt");
		rd(ADDR_STS, d, RESP_OKAY);
		chk(d, 32'h0000_0001, "done status");
		wr(ADDR_MASK, 32'h3, 4'hF, RESP_OKAY);
		t_good(GR_DOM, 16'hA5C3, 32'h0000_0000);
		chk(IRQ, 1'b1, "interrupt raised");
		rd(ADDR_STS, d, RESP_OKAY);
		repeat (2) @(posedge CORE_CLK);
		chk({d, IRQ}, 33'h2, "status cleared by read");
		wr(ADDR_IVA_HI, 32'hC0DE_0001, 4'hF, RESP_OKAY);
		t_good(GR_PAGE, 16'h0042, 32'h0000_1009);
		chk(INV_ADDR[63:32], 32'hC0DE_0001, "page address high");
		rd(ADDR_STS, d, RESP_OKAY);
		t_bad(GR_PAGE, 32'h0000_100A, 1'b0);
		t_bad(GR_NONE, 32'h0000_0000, 1'b0);
		t_bad(GR_GLOB, 32'h0000_0000, 1'b1);
		rd(8'h1C, d, RESP_SLVERR);
		chk(d, 32'h0, "unmapped read data");
		wr(8'h1C, 32'h1, 4'hF, RESP_SLVERR);
		t_freeze();
		t_rst();
		close_out();
	end
	// Cuts a hang short well beyond the few hundred cycles the sequence needs.
	initial begin
		repeat (20000) @(posedge CORE_CLK);
		mismatches++;
		$display("[ERR] %0t watchdog expired", $time);
		close_out();
	end
endmodule : tb
